// *** rtl/epx_pkg.sv ***
// Package for the extended pointer instruction decoder.
// Assumes a 16-bit instruction word, 12-bit pointers and a 21-bit PC.
package epx_pkg;
	localparam int PTR_W  = 12;
	localparam int PC_W   = 21;
	localparam int LIT6_W = 6;
	localparam int OFS_W  = 7;
	localparam logic [7:0]  OP_ADD_PTR  = 8'he8;
	localparam logic [7:0]  OP_SUB_PTR  = 8'he9;
	localparam logic [7:0]  OP_PUSH_LIT = 8'hea;
	localparam logic [7:0]  OP_MOVE_IDX = 8'heb;
	localparam logic [3:0]  OP_SECOND   = 4'hf;
	localparam logic [15:0] OP_CALL_W   = 16'h0014;
	localparam logic [1:0]  SEL_STACK_RET = 2'h3;
	localparam logic [1:0]  STACK_PTR_IDX = 2'h2;
	localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [PC_W-1:0]  PC_RESET  = 21'h00000;
	localparam int SEL_LSB = 6;
	localparam int ISMOV_BIT = 7;
	typedef enum logic [1:0] {
		EPX_EXEC  = 2'b00,
		EPX_NOP2  = 2'b01,
		EPX_WORD2 = 2'b10
	} epx_state_e;
endpackage

// *** rtl/epx_ptr_alu.sv ***
// Pointer adder and subtractor for the pointer literal instructions.
// Assumes a purely combinational use from the decoder's next-state logic.
`timescale 1ns/100ps
module epx_ptr_alu
	import epx_pkg::*;
(
	input  wire logic [PTR_W-1:0]  ptr_in,  // Current pointer value
	input  wire logic [LIT6_W-1:0] lit_in,  // Unsigned literal
	input  wire logic              sub_in,  // High to subtract
	output logic      [PTR_W-1:0]  res_out  // Result, wraps at width
);
	logic [PTR_W-1:0] ext;
	always_comb begin
		ext = {{(PTR_W-LIT6_W){1'b0}}, lit_in};
		res_out = sub_in ? ptr_in - ext : ptr_in + ext;
	end
endmodule

// *** rtl/epx_decode.sv ***
// Decoder and executor for the extended pointer instruction group.
// Assumes one instruction word per instr_valid_in pulse, issued only when
// busy_out is low, except the second move word, which is issued while busy_out is high,
// and memory writes taken by the core in the next cycle.
// Assumes the return stack and data memory sit outside, on the same clock.
// Functional notes
// - Add literal to a pointer in one cycle; select 3 adds and returns.
// - Subtract literal from a pointer in one cycle; no flag changes.
// - Select 3 subtracts from stack pointer then returns, two cycles.
// - Call to address from working register in two cycles, flags kept.
// - Two-word move from stack-indexed source to a 12-bit address.
// - Two-word move from stack-indexed source to stack-indexed target.
// - Push literal: store at stack pointer, decrement it, one cycle.
// - Except for a pending second move word, the group is decoded only while the extended set is enabled.
// - Return loads PC from return stack top; second cycle is a no-op.
`timescale 1ns/100ps
module epx_decode
	import epx_pkg::*;
(
	input  wire logic             clk_in,           // 200 MHz core clock
	input  wire logic             resetn_in,        // Sync reset, active low
	input  wire logic             ext_set_en_in,    // Extended set enable
	input  wire logic             instr_valid_in,   // Instruction word valid
	input  wire logic [15:0]      instr_in,         // Instruction word
	input  wire logic [7:0]       working_reg_in,   // Working register
	input  wire logic [PC_W-1:0]  ret_top_in,       // Return stack top
	input  wire logic [PC_W-1:0]  pc_in,            // Address after the call
	input  wire logic [7:0]       rd_data_in,       // Data read from memory
	output logic      [PTR_W-1:0] ptr0_out,         // Pointer 0
	output logic      [PTR_W-1:0] ptr1_out,         // Pointer 1
	output logic      [PTR_W-1:0] stack_ptr_out,    // Software stack pointer
	output logic                  busy_out,         // Second cycle pending
	output logic                  pc_load_out,      // Load PC pulse
	output logic      [PC_W-1:0]  pc_target_out,    // PC load value
	output logic                  push_ret_out,     // Push return addr pulse
	output logic      [PC_W-1:0]  push_addr_out,    // Return address pushed
	output logic                  pop_ret_out,      // Pop return stack pulse
	output logic                  rd_req_out,       // Memory read pulse
	output logic      [PTR_W-1:0] rd_addr_out,      // Memory read address
	output logic                  wr_req_out,       // Memory write pulse
	output logic      [PTR_W-1:0] wr_addr_out,      // Memory write address
	output logic      [7:0]       wr_data_out,      // Memory write data
	output logic                  unhandled_out     // Word not in this group
);
	// All state of the decoder, registered as one word.
	typedef struct packed {
		epx_state_e       st;
		logic             busy;
		logic [PTR_W-1:0] ptr0;
		logic [PTR_W-1:0] ptr1;
		logic [PTR_W-1:0] sp;
		logic             pc_load;
		logic [PC_W-1:0]  pc_tgt;
		logic             push_ret;
		logic [PC_W-1:0]  push_addr;
		logic             pop_ret;
		logic             rd_req;
		logic [PTR_W-1:0] rd_addr;
		logic             wr_req;
		logic [PTR_W-1:0] wr_addr;
		logic [7:0]       wr_data;
		logic             unhandled;
		logic             mov_to_idx;
	} epx_state_s;

	epx_state_s state_ff;
	epx_state_s nxt_state;
	logic [1:0]        sel;
	logic [PTR_W-1:0]  sel_ptr;
	logic [PTR_W-1:0]  alu_res;
	logic              is_add;
	logic              is_sub;
	logic              is_push;
	logic              is_move;
	logic              is_call;

	// Decoding only looks at the word; the state decides whether it is
	// taken, so a word offered while busy never reaches the pointers.
	assign sel = instr_in[SEL_LSB+1:SEL_LSB];
	assign is_add = (instr_in[15:8] == OP_ADD_PTR);
	assign is_sub = (instr_in[15:8] == OP_SUB_PTR);
	assign is_push = (instr_in[15:8] == OP_PUSH_LIT);
	assign is_move = (instr_in[15:8] == OP_MOVE_IDX);
	assign is_call = (instr_in == OP_CALL_W);

	// Select 3 maps to the stack pointer for the return variants.
	always_comb begin
		unique case (sel)
			2'h0:    sel_ptr = state_ff.ptr0;
			2'h1:    sel_ptr = state_ff.ptr1;
			default: sel_ptr = state_ff.sp;
		endcase
	end

	// One shared adder serves both the add and the subtract forms.
	epx_ptr_alu i_epx_ptr_alu (
		.ptr_in  (sel_ptr),
		.lit_in  (instr_in[LIT6_W-1:0]),
		.sub_in  (is_sub),
		.res_out (alu_res)
	);

	// Status flags are never an output here, so none can change.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.pc_load = 1'b0;
		nxt_state.push_ret = 1'b0;
		nxt_state.pop_ret = 1'b0;
		nxt_state.rd_req = 1'b0;
		nxt_state.wr_req = 1'b0;
		nxt_state.unhandled = 1'b0;
		unique case (state_ff.st)
			EPX_EXEC: begin
				if (instr_valid_in) begin
					if (!ext_set_en_in) begin
						nxt_state.unhandled = 1'b1;
					end else if (is_add || is_sub) begin
						unique case (sel)
							2'h0:    nxt_state.ptr0 = alu_res;
							2'h1:    nxt_state.ptr1 = alu_res;
							default: nxt_state.sp = alu_res;
						endcase
						// The return target is taken now; the core must
						// not change the return stack top in this cycle.
						if (sel == SEL_STACK_RET) begin
							nxt_state.pc_load = 1'b1;
							nxt_state.pc_tgt = ret_top_in;
							nxt_state.pop_ret = 1'b1;
							nxt_state.st = EPX_NOP2;
						end
					end else if (is_call) begin
						// Upper PC bits are kept from the current PC.
						nxt_state.pc_load = 1'b1;
						nxt_state.pc_tgt = {pc_in[PC_W-1:8],
						                    working_reg_in};
						nxt_state.push_ret = 1'b1;
						nxt_state.push_addr = pc_in;
						nxt_state.st = EPX_NOP2;
					end else if (is_push) begin
						// The old pointer is the address, so the write
						// and the decrement can share one cycle.
						nxt_state.wr_req = 1'b1;
						nxt_state.wr_addr = state_ff.sp;
						nxt_state.wr_data = instr_in[7:0];
						nxt_state.sp = state_ff.sp - 12'h001;
					end else if (is_move) begin
						// The offset is zero-extended onto the stack base.
						nxt_state.rd_req = 1'b1;
						nxt_state.rd_addr = state_ff.sp +
						    {5'h00, instr_in[OFS_W-1:0]};
						nxt_state.mov_to_idx = instr_in[ISMOV_BIT];
						nxt_state.st = EPX_WORD2;
					end else begin
						nxt_state.unhandled = 1'b1;
					end
				end
			end
			EPX_NOP2: begin
				// Any word offered here is dropped; it must be offered
				// again once the loaded program counter takes effect.
				nxt_state.st = EPX_EXEC;
			end
			EPX_WORD2: begin
				// The read data must stand with the second word, as no
				// copy of it is kept between the two cycles.
				if (instr_valid_in) begin
					nxt_state.st = EPX_EXEC;
					if (instr_in[15:12] == OP_SECOND) begin
						nxt_state.wr_req = 1'b1;
						nxt_state.wr_data = rd_data_in;
						if (state_ff.mov_to_idx) begin
							nxt_state.wr_addr = state_ff.sp +
							    {5'h00, instr_in[OFS_W-1:0]};
						end else begin
							nxt_state.wr_addr = instr_in[11:0];
						end
					end else begin
						nxt_state.unhandled = 1'b1;
					end
				end
			end
			default: nxt_state.st = EPX_EXEC;
		endcase
		// Busy follows the next state, so the output is a plain flop.
		nxt_state.busy = (nxt_state.st != EPX_EXEC);
	end

	// The struct clear covers every pulse, so no request can leave reset
	// active; the pointers restart at their own reset values.
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_ff <= '0;
			state_ff.ptr0 <= PTR_RESET;
			state_ff.ptr1 <= PTR_RESET;
			state_ff.sp <= PTR_RESET;
			state_ff.pc_tgt <= PC_RESET;
			state_ff.push_addr <= PC_RESET;
			state_ff.st <= EPX_EXEC;
			state_ff.busy <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Busy is registered state: the NOP or second-word cycle is pending.
	assign ptr0_out = state_ff.ptr0;
	assign ptr1_out = state_ff.ptr1;
	assign stack_ptr_out = state_ff.sp;
	assign busy_out = state_ff.busy;
	assign pc_load_out = state_ff.pc_load;
	assign pc_target_out = state_ff.pc_tgt;
	assign push_ret_out = state_ff.push_ret;
	assign push_addr_out = state_ff.push_addr;
	assign pop_ret_out = state_ff.pop_ret;
	assign rd_req_out = state_ff.rd_req;
	assign rd_addr_out = state_ff.rd_addr;
	assign wr_req_out = state_ff.wr_req;
	assign wr_addr_out = state_ff.wr_addr;
	assign wr_data_out = state_ff.wr_data;
	assign unhandled_out = state_ff.unhandled;
endmodule

// *** sim/epx_decode_monitor.sv ***
// Checker for the extended pointer decoder, bound to every epx_decode.
// Assumes the decoder's single clock and its sync active-low reset.
`timescale 1ns/100ps
module epx_decode_monitor
	import epx_pkg::*;
(
	input wire logic             clk_in,          // Core clock
	input wire logic             resetn_in,       // Sync reset, active low
	input wire logic             ext_set_en_in,   // Extended set enable
	input wire logic             instr_valid_in,  // Word valid
	input wire logic [15:0]      instr_in,        // Instruction word
	input wire logic [7:0]       working_reg_in,  // Working register
	input wire logic [PC_W-1:0]  ret_top_in,      // Return stack top
	input wire logic [PTR_W-1:0] stack_ptr_out,   // Stack pointer
	input wire logic             busy_out,        // Second cycle pending
	input wire logic             pc_load_out,     // Load PC pulse
	input wire logic [PC_W-1:0]  pc_target_out,   // PC load value
	input wire logic             push_ret_out,    // Push pulse
	input wire logic             pop_ret_out,     // Pop pulse
	input wire logic             rd_req_out,      // Read pulse
	input wire logic             wr_req_out,      // Write pulse
	input wire logic [7:0]       wr_data_out,     // Write data
	input wire logic             unhandled_out    // Refused word pulse
);
	wire take = instr_valid_in && !busy_out && ext_set_en_in;
	wire [9:0] hi = instr_in[15:6];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	group_off_a: assert property (
		instr_valid_in && !busy_out && !ext_set_en_in
		|=> unhandled_out && !wr_req_out && !pc_load_out)
		else $error("disabled group still acted");
	sub_ret_a: assert property (
		take && hi == {OP_SUB_PTR, SEL_STACK_RET}
		|=> pc_load_out && pop_ret_out && busy_out ##1 !busy_out)
		else $error("subtract and return sequence wrong");
	add_ret_a: assert property (
		take && hi == {OP_ADD_PTR, SEL_STACK_RET}
		|=> pc_load_out && pc_target_out == $past(ret_top_in))
		else $error("return target wrong");
	add_ptr_a: assert property (
		take && hi == {OP_ADD_PTR, STACK_PTR_IDX} |=> stack_ptr_out
		== $past(stack_ptr_out) + 12'($past(instr_in[5:0])))
		else $error("pointer add wrong");
	sub_ptr_a: assert property (
		take && hi == {OP_SUB_PTR, STACK_PTR_IDX} |=> stack_ptr_out
		== $past(stack_ptr_out) - 12'($past(instr_in[5:0])))
		else $error("pointer subtract wrong");
	call_w_a: assert property (
		take && instr_in == OP_CALL_W |=> pc_load_out && push_ret_out
		&& pc_target_out[7:0] == $past(working_reg_in) ##1 !busy_out)
		else $error("call through working register wrong");
	push_lit_a: assert property (
		take && instr_in[15:8] == OP_PUSH_LIT |=> wr_req_out
		&& wr_data_out == $past(instr_in[7:0])
		&& stack_ptr_out == $past(stack_ptr_out) - 12'h001)
		else $error("push literal wrong");
	move_first_a: assert property (
		take && instr_in[15:8] == OP_MOVE_IDX |=> rd_req_out && busy_out)
		else $error("move first word not handled");
endmodule
bind epx_decode epx_decode_monitor i_mon (.clk_in, .resetn_in,
	.ext_set_en_in, .instr_valid_in, .instr_in, .working_reg_in,
	.ret_top_in, .stack_ptr_out, .busy_out, .pc_load_out, .pc_target_out,
	.push_ret_out, .pop_ret_out, .rd_req_out, .wr_req_out, .wr_data_out,
	.unhandled_out);

// *** sim/epx_decode_bench.sv ***
// Self-checking bench for the extended pointer decoder.
// Assumes the decoder resets all pointers to zero; sp mirrors the stack.
`timescale 1ns/100ps
module epx_decode_bench;
	import epx_pkg::*;
	logic clk_in = 1'b0, resetn_in = 1'b0, ext_set_en_in = 1'b1;
	logic instr_valid_in = 1'b0, busy_out, pc_load_out, push_ret_out;
	logic pop_ret_out, rd_req_out, wr_req_out, unhandled_out;
	logic [15:0] instr_in = 16'h0000;
	logic [7:0] working_reg_in = 8'h5a, rd_data_in = 8'h99, wr_data_out;
	logic [PC_W-1:0] ret_top_in = 21'h1abcd, pc_in = 21'h12345;
	logic [PC_W-1:0] pc_target_out, push_addr_out;
	logic [PTR_W-1:0] ptr0_out, ptr1_out, stack_ptr_out, rd_addr_out;
	logic [PTR_W-1:0] wr_addr_out, sp = 12'h000;
	int err_total = 0, n_tests = 0;
	epx_decode i_epx_decode (.clk_in, .resetn_in, .ext_set_en_in,
		.instr_valid_in, .instr_in, .working_reg_in, .ret_top_in, .pc_in,
		.rd_data_in, .ptr0_out, .ptr1_out, .stack_ptr_out, .busy_out,
		.pc_load_out, .pc_target_out, .push_ret_out, .push_addr_out,
		.pop_ret_out, .rd_req_out, .rd_addr_out, .wr_req_out, .wr_addr_out,
		.wr_data_out, .unhandled_out);
	always #2.5 clk_in = ~clk_in;
	task automatic chk(input string nm, input logic [20:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// An idle edge first keeps valid from being rewritten in one step.
	task automatic issue(input logic [15:0] w);
		@(posedge clk_in);
		#1 instr_valid_in = 1'b1;
		instr_in = w;
		@(posedge clk_in);
		#1 instr_valid_in = 1'b0;
	endtask
	task automatic t_ptr;
		for (int s = 0; s < 3; s++) begin
			issue({OP_ADD_PTR, 2'(s), 6'h3f});
		end
		issue({OP_SUB_PTR, 2'h0, 6'h3f});
		issue({OP_SUB_PTR, 2'h2, 6'h01});
		sp = 12'h03e;
		chk("ptr0", 12'h000, ptr0_out);
		chk("ptr1", 12'h03f, ptr1_out);
		chk("stack", sp, stack_ptr_out);
	endtask
	task automatic t_ret;
		for (int i = 0; i < 2; i++) begin
			issue({i != 0 ? OP_ADD_PTR : OP_SUB_PTR,
			       SEL_STACK_RET, 6'h0a});
			sp = i != 0 ? sp + 12'h00a : sp - 12'h00a;
			chk("stack", sp, stack_ptr_out);
			chk("pop", 1'b1, pop_ret_out);
			chk("target", ret_top_in, pc_target_out);
			chk("busy", 1'b1, busy_out);
			@(posedge clk_in);
			#1 chk("busy end", 1'b0, busy_out);
		end
	endtask
	task automatic t_call;
		issue(OP_CALL_W);
		chk("call", {pc_in[20:8], working_reg_in}, pc_target_out);
		chk("push", 1'b1, push_ret_out);
		chk("push addr", pc_in, push_addr_out);
		issue({OP_PUSH_LIT, 8'h7e});
		chk("push wr", 1'b1, wr_req_out);
		chk("push addr", sp, wr_addr_out);
		chk("push data", 8'h7e, wr_data_out);
		sp = sp - 12'h001;
		chk("stack", sp, stack_ptr_out);
	endtask
	task automatic t_move;
		for (int i = 0; i < 2; i++) begin
			issue({OP_MOVE_IDX, i != 0 ? 8'h85 : 8'h05});
			chk("rd addr", sp + 12'h005, rd_addr_out);
			chk("busy", 1'b1, busy_out);
			rd_data_in = i != 0 ? 8'h3c : 8'h99;
			issue(i != 0 ? 16'hf0ff : 16'hf123);
			chk("wr", 1'b1, wr_req_out);
			chk("wr addr", i != 0 ? sp + 12'h07f : 12'h123,
			    wr_addr_out);
			chk("wr data", rd_data_in, wr_data_out);
		end
	endtask
	task automatic t_dis;
		ext_set_en_in = 1'b0;
		issue({OP_ADD_PTR, 8'h01});
		ext_set_en_in = 1'b1;
		chk("refused", 1'b1, unhandled_out);
		chk("ptr0", 12'h000, ptr0_out);
		// A second move word without its prefix aborts the move.
		issue({OP_MOVE_IDX, 8'h01});
		issue(16'h0123);
		chk("abort", 1'b1, unhandled_out);
		chk("abort wr", 1'b0, wr_req_out);
		chk("abort busy", 1'b0, busy_out);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		t_ptr();
		t_ret();
		t_call();
		t_move();
		t_dis();
		wrap_up();
	end
endmodule
